// ### shared/mfp_pkg.sv
package mfp_pkg;

   // ----------------------------------------
   // sizes and status field positions
   // ----------------------------------------
   localparam int NUM_LOOPS = 4;
   localparam int NUM_REFS = 4;
   localparam int REF_FAULT_BIT = 2;
   localparam int REF_VALID_BIT = 3;
   localparam int REF_ACTIVE_LSB = 4;

   // ----------------------------------------
   // timing counts, in core_clk cycles, and the pin reset level
   // ----------------------------------------
   localparam int CLK_DIV_FACTOR = 32;
   localparam int WDOG_STROBE_CYCLES = 32;
   localparam logic MFP_PIN_RESET = 1'b0;

   // ----------------------------------------
   // output select codes, direction bit set
   // ----------------------------------------
   localparam int DIR_BIT = 7;
   localparam logic [7:0] SEL_LOW = 8'h80;
   localparam logic [7:0] SEL_HIGH = 8'h81;
   localparam logic [7:0] SEL_CLK_DIV = 8'h82;
   localparam logic [7:0] SEL_WDOG = 8'h83;
   localparam logic [7:0] SEL_RP_CAL = 8'h84;
   localparam logic [7:0] SEL_RP_LOCK = 8'h85;
   localparam logic [7:0] SEL_RP_STABLE = 8'h86;
   localparam logic [7:0] SEL_ALL_LOCK = 8'h87;
   localparam logic [7:0] SEL_LOOP_LOCK0 = 8'h88;
   localparam logic [7:0] SEL_EE_WRITE = 8'h8C;
   localparam logic [7:0] SEL_EE_READ = 8'h8D;
   localparam logic [7:0] SEL_EE_FAULT = 8'h8E;
   localparam logic [7:0] SEL_IRQ_ANY = 8'h90;
   localparam logic [7:0] SEL_IRQ_COMMON = 8'h91;
   localparam logic [7:0] SEL_IRQ_LOOP0 = 8'h92;
   localparam logic [7:0] SEL_REF_FAULT0 = 8'hA0;
   localparam logic [7:0] SEL_REF_VALID0 = 8'hA8;
   localparam logic [7:0] SEL_REF_ACTIVE0 = 8'hB0;

   // per-loop codes: 0xC0 + 0x10 * loop + offset
   localparam logic [1:0] LOOP_GROUP = 2'h3;
   localparam logic [3:0] OFF_PHASE = 4'h0;
   localparam logic [3:0] OFF_FREQ = 4'h1;
   localparam logic [3:0] OFF_ALOCK = 4'h2;
   localparam logic [3:0] OFF_ACAL = 4'h3;
   localparam logic [3:0] OFF_ACTIVE = 4'h4;
   localparam logic [3:0] OFF_FREERUN = 4'h5;
   localparam logic [3:0] OFF_HOLD = 4'h6;
   localparam logic [3:0] OFF_SWITCH = 4'h7;
   localparam logic [3:0] OFF_HAVAIL = 4'h8;
   localparam logic [3:0] OFF_HUPD = 4'h9;
   localparam logic [3:0] OFF_CLAMP = 4'hA;
   localparam logic [3:0] OFF_SLEW = 4'hB;
   localparam logic [3:0] OFF_SYNC = 4'hC;
   localparam logic [3:0] OFF_DEMAP = 4'hD;

   // ----------------------------------------
   // status carriers
   // ----------------------------------------
   typedef struct packed {
      logic phase_lock;
      logic freq_lock;
      logic analog_lock;
      logic analog_cal;
      logic free_run;
      logic holdover;
      logic switchover;
      logic hist_avail;
      logic hist_updated;
      logic clamp;
      logic slew_limited;
      logic sync_pulse;
      logic demap_clamped;
   } mfp_loop_s;

   typedef struct packed {
      logic cal_busy;
      logic lock;
      logic stable;
   } mfp_refpll_s;

   typedef struct packed {
      logic write_busy;
      logic read_busy;
      logic fault;
   } mfp_eeprom_s;

   typedef struct packed {
      logic common;
      logic [NUM_LOOPS-1:0] loop;
   } mfp_irq_s;

   typedef enum logic [1:0] {
      STB_IDLE = 2'b01,
      STB_ACTIVE = 2'b10
   } mfp_stb_e;

endpackage

// ### verilog/mfp_pulse_src.sv
`timescale 1ns/1ps

module mfp_pulse_src
   import mfp_pkg::*;
#(
   parameter int STROBE_LEN = WDOG_STROBE_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic wd_expire,
   output logic div_clk_q,
   output logic wd_strobe_q
);

   localparam int HALF = CLK_DIV_FACTOR / 2;
   localparam int SW = $clog2(STROBE_LEN + 1);

   if (STROBE_LEN < 2 || STROBE_LEN > 4096) begin : g_chk
      $error("strobe length out of range");
   end

   logic [3:0] half_q;
   logic [SW-1:0] stb_cnt_q;
   mfp_stb_e state_q;

   // ----------------------------------------
   // clock divider, toggles every half period
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         half_q <= 4'h0;
         div_clk_q <= 1'b0;
      end else begin
         half_q <= half_q + 4'h1;
         if (half_q == 4'(HALF - 1)) begin
            div_clk_q <= ~div_clk_q;
         end
      end
   end

   // ----------------------------------------
   // watchdog strobe stretcher, retriggerable
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_q <= STB_IDLE;
         stb_cnt_q <= '0;
         wd_strobe_q <= 1'b0;
      end else begin
         case (state_q)
            STB_IDLE: begin
               if (wd_expire) begin
                  state_q <= STB_ACTIVE;
                  stb_cnt_q <= '0;
                  wd_strobe_q <= 1'b1;
               end
            end
            STB_ACTIVE: begin
               if (wd_expire) begin
                  stb_cnt_q <= '0;
               end else if (stb_cnt_q == SW'(STROBE_LEN - 1)) begin
                  state_q <= STB_IDLE;
                  wd_strobe_q <= 1'b0;
               end else begin
                  stb_cnt_q <= stb_cnt_q + SW'(1);
               end
            end
            default: begin
               state_q <= STB_IDLE;
               wd_strobe_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [SW:0] hi_len_q;
   always_ff @(posedge core_clk) begin
      if (reset || !wd_strobe_q || wd_expire) begin
         hi_len_q <= '0; // restart on each trigger
      end else begin
         hi_len_q <= hi_len_q + (SW+1)'(1);
      end
   end

   sequence s_trig;
      (state_q == STB_IDLE) && wd_expire;
   endsequence

   sequence s_hold;
      wd_strobe_q [*8];
   endsequence

   AST_STB_START: assert property (@(posedge core_clk) disable iff (reset)
      s_trig |=> s_hold)
      else $error("strobe did not start");
   AST_STB_LEN: assert property (@(posedge core_clk) disable iff (reset)
      $fell(wd_strobe_q) |-> hi_len_q == (SW+1)'(STROBE_LEN))
      else $error("strobe length wrong");
   AST_DIV_EDGE: assert property (@(posedge core_clk) disable iff (reset)
      $changed(div_clk_q) |-> $past(half_q) == 4'(HALF - 1))
      else $error("divided clock toggled off schedule");

endmodule

// ### verilog/mfp_output_select.sv
`timescale 1ns/1ps

// Operation
// - top bit set: output; 80 low, 81 high
// - code 82 gives clock divided by 32
// - code 83 gives 32-cycle watchdog strobe
// - 84-86: reference pll busy, lock, stable
// - 88-8B: loop phase, analog, reference lock
// - code 87 ands all four loop locks
// - 8C-8E: eeprom write, read, fault
// - 90 any interrupt, 91 common, 92-95 loops
// - A0-A3: reference fault, status bit 2
// - A8-AB: reference valid, status bit 3
// - B0-B3: reference active, or bits 4-7
// - C0-C3: loop zero lock and cal flags
// - loop active ors one bit across references
// - C5-C7: free run, holdover, switchover
// - C8, CA, CB: history, clamp, slew flags
// - C9 history updated, no enable needed
// - CC: loop zero distribution sync pulse
// - CD: demapping controller clamped flag
// - D0-DD: loop one, same order
// - top bit clear: pin is an input
// - loops two, three at E0 and F0
module mfp_output_select
   import mfp_pkg::*;
#(
   parameter int STROBE_LEN = WDOG_STROBE_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] pin_sel,
   input wire logic pin_in,
   input wire logic wd_expire,
   input wire mfp_refpll_s refpll_st,
   input wire mfp_eeprom_s eeprom_st,
   input wire mfp_irq_s irq_st,
   input wire logic [NUM_REFS-1:0][7:0] ref_status,
   input wire mfp_loop_s [NUM_LOOPS-1:0] loop_st,
   output logic pin_out_q,
   output logic pin_oe_q,
   output logic [6:0] ctrl_func_sel_q,
   output logic ctrl_func_level_q
);

   if (NUM_LOOPS != 4 || NUM_REFS != 4) begin : g_chk
      $error("select map serves four loops and four references");
   end

   // ----------------------------------------
   // time sources
   // ----------------------------------------
   logic div_clk;
   logic wd_strobe;

   mfp_pulse_src #(
      .STROBE_LEN(STROBE_LEN)
   ) u_pulse (
      .core_clk(core_clk),
      .reset(reset),
      .wd_expire(wd_expire),
      .div_clk_q(div_clk),
      .wd_strobe_q(wd_strobe)
   );

   // ----------------------------------------
   // derived per-loop and per-reference flags
   // ----------------------------------------
   logic [NUM_LOOPS-1:0] loop_lock;
   logic [NUM_LOOPS-1:0] loop_active;
   logic [NUM_REFS-1:0] ref_fault;
   logic [NUM_REFS-1:0] ref_valid;
   logic [NUM_REFS-1:0] ref_active;
   logic [NUM_LOOPS-1:0][NUM_REFS-1:0] act_tr;
   logic all_lock;
   logic irq_any;

   for (genvar g = 0; g < NUM_LOOPS; g++) begin : g_loop
      // combined lock of one loop
      assign loop_lock[g] = loop_st[g].phase_lock
         & loop_st[g].analog_lock & refpll_st.lock;
      for (genvar r = 0; r < NUM_REFS; r++) begin : g_ref
         assign act_tr[g][r] = ref_status[r][REF_ACTIVE_LSB + g];
      end
      // loop active on any reference
      assign loop_active[g] = |act_tr[g];
   end

   for (genvar r = 0; r < NUM_REFS; r++) begin : g_refst
      assign ref_fault[r] = ref_status[r][REF_FAULT_BIT];
      assign ref_valid[r] = ref_status[r][REF_VALID_BIT];
      assign ref_active[r] =
         |ref_status[r][REF_ACTIVE_LSB +: NUM_LOOPS];
   end

   // grouped lock and interrupt terms
   assign all_lock = &loop_lock;
   assign irq_any = irq_st.common | (|irq_st.loop);

   // ----------------------------------------
   // output select decode
   // ----------------------------------------
   logic sel_d;
   logic [1:0] lp;
   logic [3:0] off;
   mfp_loop_s cur;

   assign lp = pin_sel[5:4];
   assign off = pin_sel[3:0];
   assign cur = loop_st[lp];

   // one loop's pattern, shared by all four loops
   always_comb begin
      sel_d = 1'b0;
      if (!pin_sel[DIR_BIT]) begin
         sel_d = 1'b0;
      end else if (pin_sel[7:6] == LOOP_GROUP) begin
         case (off)
            OFF_PHASE: sel_d = cur.phase_lock;
            OFF_FREQ: sel_d = cur.freq_lock;
            OFF_ALOCK: sel_d = cur.analog_lock;
            OFF_ACAL: sel_d = cur.analog_cal;
            OFF_ACTIVE: sel_d = loop_active[lp];
            OFF_FREERUN: sel_d = cur.free_run;
            OFF_HOLD: sel_d = cur.holdover;
            OFF_SWITCH: sel_d = cur.switchover;
            OFF_HAVAIL: sel_d = cur.hist_avail;
            OFF_HUPD: sel_d = cur.hist_updated;
            OFF_CLAMP: sel_d = cur.clamp;
            OFF_SLEW: sel_d = cur.slew_limited;
            OFF_SYNC: sel_d = cur.sync_pulse;
            OFF_DEMAP: sel_d = cur.demap_clamped;
            default: sel_d = 1'b0;
         endcase
      end else begin
         case (pin_sel)
            SEL_LOW: sel_d = 1'b0;
            SEL_HIGH: sel_d = 1'b1;
            SEL_CLK_DIV: sel_d = div_clk;
            SEL_WDOG: sel_d = wd_strobe;
            SEL_RP_CAL: sel_d = refpll_st.cal_busy;
            SEL_RP_LOCK: sel_d = refpll_st.lock;
            SEL_RP_STABLE: sel_d = refpll_st.stable;
            SEL_ALL_LOCK: sel_d = all_lock;
            SEL_EE_WRITE: sel_d = eeprom_st.write_busy;
            SEL_EE_READ: sel_d = eeprom_st.read_busy;
            SEL_EE_FAULT: sel_d = eeprom_st.fault;
            SEL_IRQ_ANY: sel_d = irq_any;
            SEL_IRQ_COMMON: sel_d = irq_st.common;
            default: begin
               if (pin_sel[7:2] == SEL_LOOP_LOCK0[7:2]) begin
                  sel_d = loop_lock[pin_sel[1:0]];
               end else if (pin_sel[7:2] == SEL_IRQ_LOOP0[7:2]
                  && pin_sel[1:0] >= SEL_IRQ_LOOP0[1:0]) begin
                  sel_d = irq_st.loop[2'(pin_sel[1:0] - 2'h2)];
               end else if (pin_sel[7:2] == SEL_IRQ_LOOP0[7:2] + 6'h1
                  && pin_sel[1:0] < SEL_IRQ_LOOP0[1:0]) begin
                  sel_d = irq_st.loop[2'(pin_sel[1:0] + 2'h2)];
               end else if (pin_sel[7:2] == SEL_REF_FAULT0[7:2]) begin
                  sel_d = ref_fault[pin_sel[1:0]];
               end else if (pin_sel[7:2] == SEL_REF_VALID0[7:2]) begin
                  sel_d = ref_valid[pin_sel[1:0]];
               end else if (pin_sel[7:2] == SEL_REF_ACTIVE0[7:2]) begin
                  sel_d = ref_active[pin_sel[1:0]];
               end else begin
                  sel_d = 1'b0;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // pin drive, registered against glitches
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pin_out_q <= MFP_PIN_RESET;
         pin_oe_q <= 1'b0;
      end else begin
         pin_out_q <= sel_d;
         pin_oe_q <= pin_sel[DIR_BIT];
      end
   end

   // ----------------------------------------
   // input mode: level handed to control logic
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_func_sel_q <= 7'h00;
         ctrl_func_level_q <= 1'b0;
      end else if (!pin_sel[DIR_BIT]) begin
         ctrl_func_sel_q <= pin_sel[6:0];
         ctrl_func_level_q <= pin_in;
      end else begin
         ctrl_func_sel_q <= 7'h00;
         ctrl_func_level_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   AST_DIR_OUT: assert property (
      pin_sel[DIR_BIT] |=> pin_oe_q && !ctrl_func_level_q)
      else $error("output code did not enable the pin");
   AST_DIR_IN: assert property (
      !pin_sel[DIR_BIT] |=> !pin_oe_q
         && ctrl_func_level_q == $past(pin_in))
      else $error("input code did not pass the pin level");
   AST_STATIC: assert property (
      (pin_sel == SEL_LOW || pin_sel == SEL_HIGH)
         |=> pin_out_q == $past(pin_sel[0]))
      else $error("static level wrong");
   AST_CLK_DIV: assert property (
      pin_sel == SEL_CLK_DIV |=> pin_out_q == $past(div_clk))
      else $error("divided clock not on pin");
   AST_WDOG: assert property (
      pin_sel == SEL_WDOG [*2] ##0 $rose(wd_strobe)
         |=> pin_out_q)
      else $error("watchdog strobe not on pin");
   AST_REFPLL: assert property (
      pin_sel == SEL_RP_LOCK |=> pin_out_q == $past(refpll_st.lock))
      else $error("reference pll lock not on pin");
   AST_LOOP_LOCK: assert property (
      pin_sel == SEL_LOOP_LOCK0 && !loop_st[0].analog_lock
         |=> !pin_out_q)
      else $error("loop lock ignores analog lock");
   AST_ALL_LOCK: assert property (
      pin_sel == SEL_ALL_LOCK |=> pin_out_q == &$past(loop_lock))
      else $error("all-lock wrong");
   AST_EEPROM: assert property (
      pin_sel == SEL_EE_FAULT |=> pin_out_q == $past(eeprom_st.fault))
      else $error("eeprom fault not on pin");
   AST_IRQ: assert property (
      pin_sel == SEL_IRQ_ANY && irq_st.loop[3] |=> pin_out_q)
      else $error("interrupt or wrong");
   AST_REF_FAULT: assert property (
      pin_sel == SEL_REF_FAULT0 + 8'h03
         |=> pin_out_q == $past(ref_status[3][REF_FAULT_BIT]))
      else $error("reference fault wrong");
   AST_REF_VALID: assert property (
      pin_sel == SEL_REF_VALID0
         |=> pin_out_q == $past(ref_status[0][REF_VALID_BIT]))
      else $error("reference valid wrong");
   AST_REF_ACT: assert property (
      pin_sel == SEL_REF_ACTIVE0 + 8'h01 && ref_status[1][7]
         |=> pin_out_q)
      else $error("reference active wrong");
   AST_LOOP0: assert property (
      pin_sel == 8'hC2 |=> pin_out_q == $past(loop_st[0].analog_lock))
      else $error("loop zero flag wrong");
   AST_ACTIVE1: assert property (
      pin_sel == 8'hD4 |=> pin_out_q == $past(loop_active[1]))
      else $error("loop one active wrong");
   AST_HIST: assert property (
      pin_sel == 8'hC9 |=> pin_out_q == $past(loop_st[0].hist_updated))
      else $error("history updated not on pin");
   AST_LOOP3: assert property (
      pin_sel == 8'hFB |=> pin_out_q == $past(loop_st[3].slew_limited))
      else $error("loop three slew flag wrong");
   AST_UNUSED: assert property (
      (pin_sel == 8'h8F || pin_sel == 8'hCE || pin_sel == 8'h9F)
         |=> !pin_out_q)
      else $error("unassigned code drove high");
   AST_RP_CAL: assert property (
      pin_sel == SEL_RP_CAL |=> pin_out_q == $past(refpll_st.cal_busy))
      else $error("reference pll busy not on pin");
   AST_EE_WRITE: assert property (
      pin_sel == SEL_EE_WRITE
         |=> pin_out_q == $past(eeprom_st.write_busy))
      else $error("eeprom write busy not on pin");
   AST_IRQ_LOOP2: assert property (
      pin_sel == 8'h94 |=> pin_out_q == $past(irq_st.loop[2]))
      else $error("loop two interrupt not on pin");
   AST_ACTIVE0: assert property (
      pin_sel == 8'hC4 |=> pin_out_q == $past(ref_status[0][4]
         | ref_status[1][4] | ref_status[2][4] | ref_status[3][4]))
      else $error("loop zero active wrong");
   AST_HOLDOVER: assert property (
      pin_sel == 8'hC6 |=> pin_out_q == $past(loop_st[0].holdover))
      else $error("loop zero holdover wrong");
   AST_CLAMP: assert property (
      pin_sel == 8'hCA |=> pin_out_q == $past(loop_st[0].clamp))
      else $error("loop zero clamp wrong");
   AST_SYNC: assert property (
      pin_sel == 8'hCC |=> pin_out_q == $past(loop_st[0].sync_pulse))
      else $error("loop zero sync pulse wrong");
   AST_DEMAP: assert property (
      pin_sel == 8'hCD
         |=> pin_out_q == $past(loop_st[0].demap_clamped))
      else $error("demapping clamped flag wrong");
   AST_LOOP1: assert property (
      pin_sel == 8'hD0 |=> pin_out_q == $past(loop_st[1].phase_lock))
      else $error("loop one phase lock wrong");
   AST_LOOP2: assert property (
      pin_sel == 8'hE7 |=> pin_out_q == $past(loop_st[2].switchover))
      else $error("loop two switchover wrong");
   AST_IN_SEL: assert property (
      !pin_sel[DIR_BIT] |=> ctrl_func_sel_q == $past(pin_sel[6:0]))
      else $error("input function code not passed");

endmodule

// ### sim/mfp_board_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// board logic watching the status pin
// ----------------------------------------
module mfp_board_model (
   input wire logic core_clk,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic drive_en,
   input wire logic drive_lvl,
   output logic pin_wire,
   output logic [31:0] hi_len,
   output logic [31:0] lo_len
);
   logic last_lvl;
   logic [31:0] run_len;

   // board drives only while the device does not; pull-down otherwise
   assign pin_wire = pin_oe ? pin_out : (drive_en ? drive_lvl : 1'b0);

   // start from a quiet low line
   initial begin
      last_lvl = 1'b0;
      run_len = 32'h0000_0000;
      hi_len = 32'h0000_0000;
      lo_len = 32'h0000_0000;
   end

   // length in cycles of the last finished high and low runs
   always @(posedge core_clk) begin
      if (pin_wire !== last_lvl) begin
         if (last_lvl) begin
            hi_len <= run_len;
         end else begin
            lo_len <= run_len;
         end
         run_len <= 32'h0000_0001;
         last_lvl <= pin_wire;
      end else begin
         run_len <= run_len + 32'h0000_0001;
      end
   end
endmodule

// ### sim/tb_multifunction_pin_output_select.sv
`timescale 1ns/1ps

module tb_multifunction_pin_output_select
   import mfp_pkg::*;
();
   typedef struct packed {
      logic [7:0] code;
      logic [1:0] op;
      logic [94:0] mask;
   } mfp_row_s;

   localparam logic [1:0] OP_CONST = 2'h0;
   localparam logic [1:0] OP_OR = 2'h1;
   localparam logic [1:0] OP_AND = 2'h2;

   logic core_clk;
   logic reset;
   logic [7:0] pin_sel;
   logic wd_expire;
   logic [94:0] stat;
   mfp_refpll_s refpll_st;
   mfp_eeprom_s eeprom_st;
   mfp_irq_s irq_st;
   logic [NUM_REFS-1:0][7:0] ref_status;
   mfp_loop_s [NUM_LOOPS-1:0] loop_st;
   logic pin_out_q;
   logic pin_oe_q;
   logic [6:0] ctrl_func_sel_q;
   logic ctrl_func_level_q;
   logic pin_wire;
   logic drive_en;
   logic drive_lvl;
   logic [31:0] hi_len;
   logic [31:0] lo_len;
   logic last_exp;
   int n_mismatch;
   int n_checks;
   mfp_row_s rows[$];

   // flat status vector spread over the status ports
   assign {refpll_st, eeprom_st, irq_st, ref_status, loop_st} = stat;

   mfp_output_select #(.STROBE_LEN(WDOG_STROBE_CYCLES)) dut (
      .core_clk(core_clk),
      .reset(reset),
      .pin_sel(pin_sel),
      .pin_in(pin_wire),
      .wd_expire(wd_expire),
      .refpll_st(refpll_st),
      .eeprom_st(eeprom_st),
      .irq_st(irq_st),
      .ref_status(ref_status),
      .loop_st(loop_st),
      .pin_out_q(pin_out_q),
      .pin_oe_q(pin_oe_q),
      .ctrl_func_sel_q(ctrl_func_sel_q),
      .ctrl_func_level_q(ctrl_func_level_q)
   );

   mfp_board_model board (
      .core_clk(core_clk),
      .pin_out(pin_out_q),
      .pin_oe(pin_oe_q),
      .drive_en(drive_en),
      .drive_lvl(drive_lvl),
      .pin_wire(pin_wire),
      .hi_len(hi_len),
      .lo_len(lo_len)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [94:0] oh(input int i);
      oh = 95'h1 << i;
   endfunction

   task automatic cmp1(input string what, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic cmp_n(input string what, input logic [31:0] e,
                        input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %0d seen %0d", what, e, g);
      end
   endtask

   task automatic end_of_test();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic add_row(input logic [7:0] c, input logic [1:0] op,
                          input logic [94:0] m);
      rows.push_back('{c, op, m});
   endtask

   // one select with one status pattern, one cycle of latency
   task automatic apply(input logic [7:0] sel, input logic [94:0] st,
                        input logic e);
      @(posedge core_clk);
      pin_sel <= sel;
      stat <= st;
      #1 cmp1("pin_hold", last_exp, pin_out_q);
      @(posedge core_clk);
      #1 cmp1("pin_out", e, pin_out_q);
      cmp1("pin_oe", 1'b1, pin_oe_q);
      last_exp = e;
   endtask

   // input-mode select with the board driving the pin
   task automatic in_mode(input logic [7:0] sel, input logic lvl,
                          input logic [6:0] e_sel, input logic e_lvl,
                          input logic e_oe);
      @(posedge core_clk);
      pin_sel <= sel;
      drive_lvl <= lvl;
      repeat (2) @(posedge core_clk);
      #1 cmp_n("func_sel", {25'h0, e_sel}, {25'h0, ctrl_func_sel_q});
      cmp1("func_level", e_lvl, ctrl_func_level_q);
      cmp1("pin_oe", e_oe, pin_oe_q);
      cmp1("pin_out", 1'b0, pin_out_q);
   endtask

   // ----------------------------------------
   // code table
   // ----------------------------------------
   task automatic build_rows();
      logic [94:0] m;
      logic [94:0] all;
      logic [7:0] spare[11];
      spare = '{8'h8F, 8'h96, 8'hA4, 8'hAC, 8'hB4, 8'hBF, 8'hCE, 8'hCF,
                8'hDE, 8'hFE, 8'hFF};
      add_row(8'h80, OP_CONST, 95'h0);
      add_row(8'h81, OP_CONST, 95'h1);
      add_row(8'h84, OP_OR, oh(94));
      add_row(8'h85, OP_OR, oh(93));
      add_row(8'h86, OP_OR, oh(92));
      all = '0;
      for (int n = 0; n < NUM_LOOPS; n++) begin
         m = oh(n * 13 + 12) | oh(n * 13 + 10) | oh(93);
         add_row(8'(8'h88 + n), OP_AND, m);
         all = all | m;
         add_row(8'(8'h92 + n), OP_OR, oh(84 + n));
      end
      add_row(8'h87, OP_AND, all);
      add_row(8'h8C, OP_OR, oh(91));
      add_row(8'h8D, OP_OR, oh(90));
      add_row(8'h8E, OP_OR, oh(89));
      add_row(8'h90, OP_OR, oh(88) | oh(87) | oh(86) | oh(85) | oh(84));
      add_row(8'h91, OP_OR, oh(88));
      for (int r = 0; r < NUM_REFS; r++) begin
         add_row(8'(8'hA0 + r), OP_OR, oh(52 + r * 8 + REF_FAULT_BIT));
         add_row(8'(8'hA8 + r), OP_OR, oh(52 + r * 8 + REF_VALID_BIT));
         m = oh(52 + r * 8 + 4) | oh(52 + r * 8 + 5);
         m = m | oh(52 + r * 8 + 6) | oh(52 + r * 8 + 7);
         add_row(8'(8'hB0 + r), OP_OR, m);
      end
      for (int n = 0; n < NUM_LOOPS; n++) begin
         for (int off = 0; off < 14; off++) begin
            m = (off < 4) ? oh(n * 13 + 12 - off) : oh(n * 13 + 13 - off);
            if (off == 4) begin
               m = '0;
               for (int r = 0; r < NUM_REFS; r++) begin
                  m = m | oh(52 + r * 8 + REF_ACTIVE_LSB + n);
               end
            end
            add_row(8'(8'hC0 + 16 * n + off), OP_OR, m);
         end
      end
      foreach (spare[k]) begin
         add_row(spare[k], OP_CONST, 95'h0);
      end
   endtask

   // or rows: every source bit alone, and every other bit set; and rows: all sources set, then each source bit cleared alone
   task automatic run_rows();
      foreach (rows[k]) begin
         case (rows[k].op)
            OP_CONST: begin
               apply(rows[k].code, '1, rows[k].mask[0]);
               apply(rows[k].code, '0, rows[k].mask[0]);
            end
            OP_OR: begin
               apply(rows[k].code, ~rows[k].mask, 1'b0);
               for (int i = 0; i < 95; i++) begin
                  if (rows[k].mask[i]) begin
                     apply(rows[k].code, oh(i), 1'b1);
                  end
               end
            end
            default: begin
               apply(rows[k].code, rows[k].mask, 1'b1);
               for (int i = 0; i < 95; i++) begin
                  if (rows[k].mask[i]) begin
                     apply(rows[k].code, ~oh(i), 1'b0);
                  end
               end
            end
         endcase
      end
   endtask

   // ----------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      end_of_test();
   end

   initial begin
      reset = 1'b1;
      pin_sel = 8'h81;
      wd_expire = 1'b0;
      stat = '1;
      drive_en = 1'b0;
      drive_lvl = 1'b0;
      last_exp = 1'b1;
      n_mismatch = 0;
      n_checks = 0;
      build_rows();
      repeat (3) @(posedge core_clk);
      #1 cmp1("oe_in_reset", 1'b0, pin_oe_q);
      cmp1("out_in_reset", 1'b0, pin_out_q);
      @(posedge core_clk);
      reset <= 1'b0;
      repeat (2) @(posedge core_clk);
      run_rows();
      // pin as input, board driving both levels, then back
      @(posedge core_clk);
      drive_en <= 1'b1;
      in_mode(8'h03, 1'b1, 7'h03, 1'b1, 1'b0);
      in_mode(8'h7F, 1'b0, 7'h7F, 1'b0, 1'b0);
      in_mode(8'h80, 1'b1, 7'h00, 1'b0, 1'b1);
      // divided clock period
      @(posedge core_clk);
      pin_sel <= 8'h82;
      repeat (100) @(posedge core_clk);
      #1 cmp_n("div_high", CLK_DIV_FACTOR / 2, hi_len);
      cmp_n("div_low", CLK_DIV_FACTOR / 2, lo_len);
      // single watchdog strobe, then a retrigger ten cycles in
      @(posedge core_clk);
      pin_sel <= 8'h83;
      repeat (40) @(posedge core_clk);
      wd_expire <= 1'b1;
      @(posedge core_clk);
      wd_expire <= 1'b0;
      repeat (60) @(posedge core_clk);
      #1 cmp_n("strobe_len", WDOG_STROBE_CYCLES, hi_len);
      @(posedge core_clk);
      wd_expire <= 1'b1;
      @(posedge core_clk);
      wd_expire <= 1'b0;
      repeat (9) @(posedge core_clk);
      wd_expire <= 1'b1;
      @(posedge core_clk);
      wd_expire <= 1'b0;
      repeat (60) @(posedge core_clk);
      #1 cmp_n("retrig_len", WDOG_STROBE_CYCLES + 10, hi_len);
      end_of_test();
   end
endmodule
